// ---- pkg/cncsp_params.svh ----
`ifndef CNCSP_PARAMS_SVH
`define CNCSP_PARAMS_SVH
`define CNCSP_CLK_HZ      100000000
`define CNCSP_BAUD        19200
`define CNCSP_CNT_W       16
`define CNCSP_STOP_BIT    4'h9
`define CNCSP_SOF         8'h3e
`define CNCSP_EOF         8'h3c
`define CNCSP_ZERO        8'h30
`define CNCSP_HEX_A_OFS   8'h37
`define CNCSP_HEX_TEN     4'ha
`define CNCSP_ID_LEN      4'h3
`define CNCSP_MIN_BODY    4'h5
`define CNCSP_WAKE_BODY   4'h6
`define CNCSP_N_MAX       4'hf
`define CNCSP_ID_SLEEP    24'h303836
`define CNCSP_ID_WAKE     24'h303835
`define CNCSP_ID_ERR      24'h455252
`define CNCSP_DEV_LAST    3'h6
`define CNCSP_CTL_LAST    3'h6
`define CNCSP_BOOT_SAMPLE 2'h2
`define CNCSP_BOOT_DONE   2'h3
`define CNCSP_DI_START    0
`define CNCSP_DI_HOLD     1
`define CNCSP_DI_PIERCE   2
`define CNCSP_DI_CORNER   3
`define CNCSP_DI_POWER    4
`define CNCSP_SW_RSVD     2
`define CNCSP_REG_CMD     4'h0
`define CNCSP_REG_STAT    4'h4
`define CNCSP_REG_RESP    4'h8
`define CNCSP_REG_DISC    4'hc
`define CNCSP_STAT_CLR    1
`define CNCSP_OKAY        2'h0
`define CNCSP_SLVERR      2'h2
`endif

// ---- pkg/cncsp_pkg.sv ----
`include "cncsp_params.svh"
package cncsp_pkg;
  typedef struct packed {
    logic                    busy;
    logic                    done;
    logic [`CNCSP_CNT_W-1:0] cnt;
    logic [3:0]              bitn;
    logic [7:0]              sh;
  } cncsp_rx_t;
  typedef struct packed {
    logic                    busy;
    logic                    done;
    logic [`CNCSP_CNT_W-1:0] cnt;
    logic [3:0]              bitn;
    logic [9:0]              sh;
  } cncsp_tx_t;
  typedef struct packed {
    logic        act;
    logic        fin;
    logic [3:0]  n;
    logic [23:0] id;
    logic [7:0]  dat;
    logic [7:0]  h1;
    logic [7:0]  h0;
    logic [7:0]  sum;
  } cncsp_prs_t;
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [4:0]  ds1;
    logic [4:0]  ds2;
    logic [2:0]  sw1;
    logic [2:0]  sw2;
    cncsp_rx_t   rx;
    cncsp_prs_t  prs;
    cncsp_tx_t   tx;
    logic        awake;
    logic [1:0]  boot;
    logic        pend;
    logic [2:0]  ridx;
    logic [23:0] rid;
    logic        tx_d;
    logic        tx_oe_n;
    logic [3:0]  motion_n;
    logic        fault_n;
    logic        nrdy_n;
    logic        rdn_n;
    logic [4:0]  act;
    logic        cmd_v;
    logic [23:0] cmd_id;
    logic [7:0]  cmd_dat;
  } cncsp_dev_t;
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [6:0]  ds1;
    logic [6:0]  ds2;
    cncsp_rx_t   rx;
    cncsp_prs_t  prs;
    cncsp_tx_t   tx;
    logic        pend;
    logic [2:0]  idx;
    logic [23:0] cid;
    logic [7:0]  cdat;
    logic        rdy;
    logic        ok;
    logic [23:0] rid;
    logic [4:0]  disc;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        line;
  } cncsp_ctl_t;

  // Upper-case hexadecimal digit for a checksum nibble.
  function automatic logic [7:0] cncsp_hex(input logic [3:0] v);
    return (v < `CNCSP_HEX_TEN) ? `CNCSP_ZERO + {4'h0, v} : `CNCSP_HEX_A_OFS + {4'h0, v};
  endfunction : cncsp_hex

  function automatic logic [7:0] cncsp_sum3(input logic [23:0] id);
    return id[23:16] + id[15:8] + id[7:0];
  endfunction : cncsp_sum3

  // One clock of a receiver that samples mid-bit; a false start is dropped.
  function automatic cncsp_rx_t cncsp_rx_step(input cncsp_rx_t r, input logic ln,
                                              input logic [`CNCSP_CNT_W-1:0] full);
    cncsp_rx_t q;
    q      = r;
    q.done = 1'b0;
    if (!r.busy)
    begin
      if (!ln)
      begin
        q.busy = 1'b1;
        q.cnt  = full >> 1;
        q.bitn = 4'h0;
      end
    end
    else if (r.cnt != '0)
      q.cnt = r.cnt - 1'b1;
    else
    begin
      q.cnt  = full - 1'b1;
      q.bitn = r.bitn + 1'b1;
      if (r.bitn == 4'h0)
        q.busy = !ln;
      else if (r.bitn == `CNCSP_STOP_BIT)
      begin
        q.busy = 1'b0;
        q.done = ln; // A missing stop bit discards the character.
      end
      else
        q.sh = {ln, r.sh[7:1]};
    end
    return q;
  endfunction : cncsp_rx_step

  function automatic cncsp_tx_t cncsp_tx_load(input logic [7:0] ch, input logic [`CNCSP_CNT_W-1:0] full);
    cncsp_tx_t q;
    q      = '0;
    q.busy = 1'b1;
    q.cnt  = full - 1'b1;
    q.sh   = {1'b1, ch, 1'b0};
    return q;
  endfunction : cncsp_tx_load

  function automatic cncsp_tx_t cncsp_tx_step(input cncsp_tx_t t, input logic [`CNCSP_CNT_W-1:0] full);
    cncsp_tx_t q;
    q      = t;
    q.done = 1'b0;
    if (t.busy && t.cnt != '0)
      q.cnt = t.cnt - 1'b1;
    else if (t.busy)
    begin
      q.cnt  = full - 1'b1;
      q.sh   = {1'b1, t.sh[9:1]};
      q.bitn = t.bitn + 1'b1;
      if (t.bitn == `CNCSP_STOP_BIT)
      begin
        q.busy = 1'b0;
        q.done = 1'b1;
      end
    end
    return q;
  endfunction : cncsp_tx_step

  // Frame parser: a start mark restarts, the last two body characters are the checksum.
  function automatic cncsp_prs_t cncsp_prs_step(input cncsp_prs_t p, input logic [7:0] b);
    cncsp_prs_t q;
    q     = p;
    q.fin = 1'b0;
    if (b == `CNCSP_SOF)
    begin
      q     = '0;
      q.act = 1'b1;
    end
    else if (p.act && b == `CNCSP_EOF)
    begin
      q.act = 1'b0;
      q.fin = 1'b1;
    end
    else if (p.act)
    begin
      if (p.n != `CNCSP_N_MAX)
        q.n = p.n + 1'b1;
      if (p.n < `CNCSP_ID_LEN)
        q.id = {p.id[15:0], b};
      if (p.n == `CNCSP_ID_LEN)
        q.dat = b;
      q.h1  = p.h0;
      q.h0  = b;
      q.sum = p.sum + b;
    end
    return q;
  endfunction : cncsp_prs_step

  function automatic logic cncsp_ck_ok(input cncsp_prs_t p);
    logic [7:0] s;
    s = p.sum - p.h1 - p.h0;
    return p.n >= `CNCSP_MIN_BODY && cncsp_hex(s[7:4]) == p.h1 && cncsp_hex(s[3:0]) == p.h0;
  endfunction : cncsp_ck_ok
endpackage : cncsp_pkg

// ---- pkg/cncsp_if.sv ----
`timescale 1ns/1ps
interface cncsp_if;
  // Controller transmit line, idle high.
  logic       ctl_line;
  // Device transmitter and its enable; the line floats high when released.
  logic       dev_tx_d;
  logic       dev_tx_oe_n;
  logic       dev_line;
  // Discrete inputs of the device, active low.
  logic       start_n;
  logic       hold_n;
  logic       pierce_n;
  logic       corner_n;
  logic       power_n;
  // Discrete outputs of the device, active low.
  logic [3:0] motion_n;
  logic       fault_n;
  logic       not_ready_n;
  logic       rampdown_n;

  // A released driver leaves the failsafe-biased pair at the idle level.
  assign dev_line = dev_tx_oe_n ? 1'b1 : dev_tx_d;

  modport dev (input ctl_line, start_n, hold_n, pierce_n, corner_n, power_n,
               output dev_tx_d, dev_tx_oe_n, motion_n, fault_n, not_ready_n, rampdown_n);
  modport ctl (output ctl_line, start_n, hold_n, pierce_n, corner_n, power_n,
               input dev_line, motion_n, fault_n, not_ready_n, rampdown_n);
endinterface : cncsp_if

// ---- verilog/cncsp_device.sv ----
`timescale 1ns/1ps
`include "cncsp_params.svh"
module cncsp_device #(
  parameter logic [`CNCSP_CNT_W-1:0] BIT_CYCLES = `CNCSP_CNT_W'(`CNCSP_CLK_HZ / `CNCSP_BAUD)
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Link toward the controller.
  cncsp_if.dev             link,
  // Unit straps: switch 2, 3, 4 on bits 0..2, and the motion jumper.
  input  wire logic [2:0]  sw_on,
  input  wire logic [1:0]  motion_sel,
  // Status from the cutting process.
  input  wire logic        arc_transferred,
  input  wire logic        error_active,
  input  wire logic        start_blocked,
  input  wire logic        rampdown_bad,
  // Orders to the cutting process.
  output logic             arc_fire,
  output logic             ign_hold,
  output logic             pierce_gas,
  output logic             corner_cur,
  output logic             main_power,
  output logic             port_awake,
  // Good commands addressed to this unit.
  output logic             cmd_valid,
  output logic [23:0]      cmd_id,
  output logic [7:0]       cmd_data
);
  import cncsp_pkg::*;

  cncsp_dev_t r_reg;
  cncsp_dev_t r_next;
  logic       ck_ok;
  logic [7:0] my_digit;
  logic [7:0] reply_ck;
  logic [7:0] reply_ch;

  // Checks on the frame that has just ended, and this unit's ID as a digit.
  // checksum compare
  assign ck_ok    = cncsp_ck_ok(r_reg.prs);
  assign my_digit = `CNCSP_ZERO + {6'h0, r_reg.sw2[1:0]};
  assign reply_ck = cncsp_sum3(r_reg.rid);

  // Character of the reply frame at the current index.
  always_comb
  begin
    case (r_reg.ridx)
      3'h0:    reply_ch = `CNCSP_SOF;
      3'h1:    reply_ch = r_reg.rid[23:16];
      3'h2:    reply_ch = r_reg.rid[15:8];
      3'h3:    reply_ch = r_reg.rid[7:0];
      3'h4:    reply_ch = cncsp_hex(reply_ck[7:4]);
      3'h5:    reply_ch = cncsp_hex(reply_ck[3:0]);
      default: reply_ch = `CNCSP_EOF;
    endcase
  end

  // Next state of the whole port.
  always_comb
  begin
    r_next       = r_reg;
    r_next.cmd_v = 1'b0;
    // The link line, discrete inputs and switch straps pass two flops; inversion ahead of them is free of hazards.
    r_next.s1    = link.ctl_line;
    r_next.s2    = r_reg.s1;
    r_next.ds1   = ~{link.power_n, link.corner_n, link.pierce_n, link.hold_n, link.start_n};
    r_next.ds2   = r_reg.ds1;
    r_next.sw1   = sw_on;
    r_next.sw2   = r_reg.sw1;

    // Switch levels are settled once both sync flops have filled after reset.
    if (r_reg.boot != `CNCSP_BOOT_DONE)
      r_next.boot = r_reg.boot + 1'b1;
    if (r_reg.boot == `CNCSP_BOOT_SAMPLE)
      r_next.awake = r_reg.sw2 == 3'h0;

    r_next.rx      = cncsp_rx_step(r_reg.rx, r_reg.s2, BIT_CYCLES);
    r_next.prs     = r_reg.prs;
    r_next.prs.fin = 1'b0;
    if (r_reg.rx.done)
      r_next.prs = cncsp_prs_step(r_reg.prs, r_reg.rx.sh);

    // A frame is judged one cycle after its end mark; a reply in progress is not
    // disturbed, so a frame arriving while replying gets no answer.
    if (r_reg.prs.fin && r_reg.boot == `CNCSP_BOOT_DONE)
    begin
      if (ck_ok && r_reg.prs.id == `CNCSP_ID_SLEEP)
        r_next.awake = 1'b0;
      else if (ck_ok && r_reg.prs.id == `CNCSP_ID_WAKE && r_reg.prs.n >= `CNCSP_WAKE_BODY
               && r_reg.prs.dat == my_digit && !r_reg.sw2[`CNCSP_SW_RSVD])
      begin
        r_next.awake = 1'b1;
        if (!r_reg.pend)
        begin
          r_next.pend = 1'b1;
          r_next.ridx = 3'h0;
          r_next.rid  = r_reg.prs.id;
        end
      end
      else if (r_reg.awake && !r_reg.pend)
      begin
        r_next.pend = 1'b1;
        r_next.ridx = 3'h0;
        r_next.rid  = ck_ok ? r_reg.prs.id : `CNCSP_ID_ERR;
        r_next.cmd_v   = ck_ok;
        r_next.cmd_id  = r_reg.prs.id;
        r_next.cmd_dat = r_reg.prs.dat;
      end
    end

    // Reply transmitter: one character at a time until the end mark has gone.
    r_next.tx = cncsp_tx_step(r_reg.tx, BIT_CYCLES);
    if (r_reg.tx.done)
    begin
      if (r_reg.ridx == `CNCSP_DEV_LAST)
        r_next.pend = 1'b0;
      else
        r_next.ridx = r_reg.ridx + 1'b1;
    end
    else if (r_reg.pend && !r_reg.tx.busy)
      r_next.tx = cncsp_tx_load(reply_ch, BIT_CYCLES);
    r_next.tx_d    = !r_next.tx.busy || r_next.tx.sh[0];
    r_next.tx_oe_n = !r_next.pend;

    // Orders follow the synchronised discrete inputs level for level.
    // fire on start
    r_next.act = r_reg.ds2;

    for (int i = 0; i < 4; i++)
      r_next.motion_n[i] = !(arc_transferred && motion_sel == 2'(i));
    r_next.fault_n = !error_active;
    r_next.nrdy_n  = !start_blocked;
    r_next.rdn_n   = !rampdown_bad;

    if (!aresetn)
    begin
      r_next          = '0;
      r_next.s1       = 1'b1;
      r_next.s2       = 1'b1;
      r_next.tx_d     = 1'b1;
      r_next.tx_oe_n  = 1'b1;
      r_next.motion_n = 4'hf;
      r_next.fault_n  = 1'b1;
      r_next.nrdy_n   = 1'b1;
      r_next.rdn_n    = 1'b1;
    end
  end

  // Single state register; reset is applied through the next-state logic.
  always_ff @(posedge aclk)
  begin
    r_reg <= r_next;
  end

  // Outputs straight from the state register.
  assign link.dev_tx_d    = r_reg.tx_d;
  assign link.dev_tx_oe_n = r_reg.tx_oe_n;
  assign link.motion_n    = r_reg.motion_n;
  assign link.fault_n     = r_reg.fault_n;
  assign link.not_ready_n = r_reg.nrdy_n;
  assign link.rampdown_n  = r_reg.rdn_n;
  assign arc_fire         = r_reg.act[`CNCSP_DI_START];
  assign ign_hold         = r_reg.act[`CNCSP_DI_HOLD];
  assign pierce_gas       = r_reg.act[`CNCSP_DI_PIERCE];
  assign corner_cur       = r_reg.act[`CNCSP_DI_CORNER];
  assign main_power       = r_reg.act[`CNCSP_DI_POWER];
  assign port_awake       = r_reg.awake;
  assign cmd_valid        = r_reg.cmd_v;
  assign cmd_id           = r_reg.cmd_id;
  assign cmd_data         = r_reg.cmd_dat;
endmodule : cncsp_device

// ---- verilog/cncsp_ctl.sv ----
`timescale 1ns/1ps
`include "cncsp_params.svh"
module cncsp_ctl #(
  parameter logic [`CNCSP_CNT_W-1:0] BIT_CYCLES = `CNCSP_CNT_W'(`CNCSP_CLK_HZ / `CNCSP_BAUD)
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Link toward the device.
  cncsp_if.ctl             link
);
  import cncsp_pkg::*;

  cncsp_ctl_t  r_reg;
  cncsp_ctl_t  r_next;
  logic        has_dat;
  logic [7:0]  ck;
  logic [2:0]  pos;
  logic [7:0]  ch;
  logic [31:0] wmask;
  logic [31:0] wval;

  // Outgoing frame: start, id, optional data, checksum, end.
  assign has_dat = r_reg.cdat != 8'h00;
  assign ck      = cncsp_sum3(r_reg.cid) + r_reg.cdat;
  assign pos     = (has_dat && r_reg.idx > 3'h3) ? r_reg.idx - 3'h1 : r_reg.idx;
  assign wmask   = {{8{r_reg.wstrb[3]}}, {8{r_reg.wstrb[2]}}, {8{r_reg.wstrb[1]}}, {8{r_reg.wstrb[0]}}};
  assign wval    = r_reg.wdata & wmask;

  always_comb
  begin
    case (pos)
      3'h0:    ch = `CNCSP_SOF;
      3'h1:    ch = r_reg.cid[23:16];
      3'h2:    ch = r_reg.cid[15:8];
      3'h3:    ch = (has_dat && r_reg.idx == 3'h4) ? r_reg.cdat : r_reg.cid[7:0];
      3'h4:    ch = cncsp_hex(ck[7:4]);
      3'h5:    ch = cncsp_hex(ck[3:0]);
      default: ch = `CNCSP_EOF;
    endcase
  end

  always_comb
  begin
    r_next     = r_reg;
    r_next.s1  = link.dev_line;
    r_next.s2  = r_reg.s1;
    r_next.ds1 = ~{link.rampdown_n, link.not_ready_n, link.fault_n, link.motion_n};
    r_next.ds2 = r_reg.ds1;

    // Write channels are taken independently; the response follows both.
    if (awvalid && r_reg.awready)
    begin
      r_next.aw_got = 1'b1;
      r_next.waddr  = awaddr;
    end
    if (wvalid && r_reg.wready)
    begin
      r_next.w_got = 1'b1;
      r_next.wdata = wdata;
      r_next.wstrb = wstrb;
    end
    if (bvalid && bready)
      r_next.bvalid = 1'b0;
    if (r_reg.aw_got && r_reg.w_got)
    begin
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = `CNCSP_OKAY;
      case (r_reg.waddr)
        `CNCSP_REG_CMD:
          // A command written while a frame is still going out is refused.
          if (r_reg.pend)
            r_next.bresp = `CNCSP_SLVERR;
          else
          begin
            r_next.cid  = wval[23:0];
            r_next.cdat = wval[31:24];
            r_next.pend = 1'b1;
            r_next.idx  = 3'h0;
          end
        `CNCSP_REG_STAT:
          if (wval[`CNCSP_STAT_CLR])
            r_next.rdy = 1'b0;
        `CNCSP_REG_DISC: r_next.disc = (r_reg.disc & ~wmask[4:0]) | wval[4:0];
        `CNCSP_REG_RESP: r_next.bresp = `CNCSP_OKAY;
        default:         r_next.bresp = `CNCSP_SLVERR;
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (rvalid && rready)
      r_next.rvalid = 1'b0;
    if (arvalid && r_reg.arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = `CNCSP_OKAY;
      case (araddr)
        `CNCSP_REG_CMD:  r_next.rdata = {r_reg.cdat, r_reg.cid};
        `CNCSP_REG_STAT: r_next.rdata = {29'h0, r_reg.ok, r_reg.rdy, r_reg.pend};
        `CNCSP_REG_RESP: r_next.rdata = {8'h00, r_reg.rid};
        `CNCSP_REG_DISC: r_next.rdata = {17'h0, r_reg.ds2, 3'h0, r_reg.disc};
        default:
        begin
          r_next.rdata = 32'h0;
          r_next.rresp = `CNCSP_SLVERR;
        end
      endcase
    end
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready  = !r_next.w_got && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;

    // Frame transmitter.
    r_next.tx = cncsp_tx_step(r_reg.tx, BIT_CYCLES);
    if (r_reg.tx.done)
    begin
      if (r_reg.idx == (has_dat ? `CNCSP_CTL_LAST + 3'h1 : `CNCSP_CTL_LAST))
        r_next.pend = 1'b0;
      else
        r_next.idx = r_reg.idx + 1'b1;
    end
    else if (r_reg.pend && !r_reg.tx.busy)
      r_next.tx = cncsp_tx_load(ch, BIT_CYCLES);
    r_next.line = !r_next.tx.busy || r_next.tx.sh[0];

    // Reply receiver; a new reply sets the flag even in the cycle it is cleared.
    r_next.rx      = cncsp_rx_step(r_reg.rx, r_reg.s2, BIT_CYCLES);
    r_next.prs     = r_reg.prs;
    r_next.prs.fin = 1'b0;
    if (r_reg.rx.done)
      r_next.prs = cncsp_prs_step(r_reg.prs, r_reg.rx.sh);
    if (r_reg.prs.fin)
    begin
      r_next.rdy = 1'b1;
      r_next.ok  = cncsp_ck_ok(r_reg.prs);
      r_next.rid = r_reg.prs.id;
    end

    if (!aresetn)
    begin
      r_next      = '0;
      r_next.s1   = 1'b1;
      r_next.s2   = 1'b1;
      r_next.line = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    r_reg <= r_next;
  end

  // Outputs straight from the state register; discrete orders drive pins low.
  assign awready       = r_reg.awready;
  assign wready        = r_reg.wready;
  assign bvalid        = r_reg.bvalid;
  assign bresp         = r_reg.bresp;
  assign arready       = r_reg.arready;
  assign rvalid        = r_reg.rvalid;
  assign rdata         = r_reg.rdata;
  assign rresp         = r_reg.rresp;
  assign link.ctl_line = r_reg.line;
  assign link.start_n  = !r_reg.disc[`CNCSP_DI_START];
  assign link.hold_n   = !r_reg.disc[`CNCSP_DI_HOLD];
  assign link.pierce_n = !r_reg.disc[`CNCSP_DI_PIERCE];
  assign link.corner_n = !r_reg.disc[`CNCSP_DI_CORNER];
  assign link.power_n  = !r_reg.disc[`CNCSP_DI_POWER];
endmodule : cncsp_ctl

// ---- bench/cncsp_monitor.sv ----
`timescale 1ns/1ps
module cncsp_monitor #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and reset.
  input wire logic       aclk,
  input wire logic       aresetn,
  // Serial lines.
  input wire logic       ctl_line,
  input wire logic       dev_tx_d,
  input wire logic       dev_tx_oe_n,
  // Discrete pins.
  input wire logic       start_n,
  input wire logic       power_n,
  input wire logic [3:0] motion_n,
  input wire logic       fault_n
);
  // A reply is seven characters of ten bits, each followed by two idle clocks before the next load.
  // The window allows a few edges of slack.
  localparam int R_LO = 7 * (10 * BIT_CYCLES + 2) - 4;
  localparam int R_HI = 7 * (10 * BIT_CYCLES + 2) + 4;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_reset_off: assert property ($rose(aresetn) |-> dev_tx_oe_n && dev_tx_d)
    else $error("transmitter driven out of reset");
  a_pins_reset_idle: assert property ($rose(aresetn) |-> start_n && power_n && fault_n && motion_n == 4'hf && ctl_line)
    else $error("pin not idle out of reset");
  a_reply_start_bit: assert property ($fell(dev_tx_oe_n) |-> ##[0:1] !dev_tx_d)
    else $error("reply without start bit");
  a_reply_holds: assert property ($fell(dev_tx_oe_n) |=> !dev_tx_oe_n [*8])
    else $error("driver released too early");
  a_stop_then_off: assert property ($rose(dev_tx_oe_n) |-> $past(dev_tx_d))
    else $error("driver released during a low bit");
  a_reply_length: assert property ($fell(dev_tx_oe_n) |-> ##[R_LO:R_HI] $rose(dev_tx_oe_n))
    else $error("reply length wrong");
  a_motion_single: assert property ($countones(~motion_n) <= 1)
    else $error("more than one motion output");
  a_half_duplex: assert property (!dev_tx_oe_n |-> ctl_line)
    else $error("controller sends during a reply");
  // Main scenarios.
  c_reply: cover property ($fell(dev_tx_oe_n));
  c_motion: cover property (motion_n != 4'hf);
  c_fault: cover property (!fault_n);
endmodule : cncsp_monitor

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        aclk, aresetn, arc_transferred, port_awake;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, motion_sel;
  logic [2:0]  sw_on, stat_in;
  wire  [4:0]  orders;
  logic [23:0] cmd_id;
  logic [7:0]  cmd_data;
  int          fail_count, num_checks;
  cncsp_if cncsp_if_inst ();
  // Both ends share a short bit time so frames stay brief.
  cncsp_ctl #(.BIT_CYCLES(16'h8)) cncsp_ctl_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(cncsp_if_inst));
  cncsp_device #(.BIT_CYCLES(16'h8)) cncsp_device_inst (.aclk(aclk), .aresetn(aresetn), .link(cncsp_if_inst),
    .sw_on(sw_on), .motion_sel(motion_sel), .arc_transferred(arc_transferred), .error_active(stat_in[0]),
    .start_blocked(stat_in[1]), .rampdown_bad(stat_in[2]), .arc_fire(orders[0]), .ign_hold(orders[1]),
    .pierce_gas(orders[2]), .corner_cur(orders[3]), .main_power(orders[4]), .port_awake(port_awake),
    .cmd_valid(), .cmd_id(cmd_id), .cmd_data(cmd_data));
  cncsp_monitor #(.BIT_CYCLES(8)) cncsp_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .ctl_line(cncsp_if_inst.ctl_line), .dev_tx_d(cncsp_if_inst.dev_tx_d),
    .dev_tx_oe_n(cncsp_if_inst.dev_tx_oe_n), .start_n(cncsp_if_inst.start_n),
    .power_n(cncsp_if_inst.power_n), .motion_n(cncsp_if_inst.motion_n), .fault_n(cncsp_if_inst.fault_n));
  // Free-running system clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Write with both channels offered together; bready stays high throughout.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : axr
  task automatic rdc(input string s, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(s, e, d & m);
  endtask : rdc
  // Clears the reply flag, sends, then polls long enough for a full reply.
  task automatic cmd(input logic [31:0] c, output logic got);
    logic [31:0] d;
    logic [1:0]  r;
    axw(4'h4, 32'h2, r);
    axw(4'h0, c, r);
    chk("cmd bresp", 32'h0, 32'(r));
    got = 1'b0;
    for (int n = 0; n < 700 && !got; n++)
    begin
      axr(4'h4, d, r);
      got = d[1];
    end
  endtask : cmd
  task automatic do_reset(input logic [2:0] s);
    sw_on   <= s;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask : do_reset
  task automatic t_serial;
    logic g;
    logic [31:0] d;
    logic [1:0]  r;
    axr(4'h2, d, r);
    chk("unmapped rresp", 32'h2, 32'(r));
    chk("awake id0", 32'h1, 32'(port_awake));
    cmd({8'h0, 24'h303031}, g);
    chk("echo", 32'h1, 32'(g));
    rdc("echo id", 4'h8, 32'hffffff, 32'h303031);
    rdc("checksum", 4'h4, 32'h4, 32'h4);
    chk("parsed id", 32'h303031, 32'(cmd_id));
    // A start mark as data restarts the frame, so the unit sees a body too short to be good.
    cmd({8'h3e, 24'h303031}, g);
    chk("error reply", 32'h1, 32'(g));
    rdc("error id", 4'h8, 32'hffffff, 32'h455252);
    cmd({8'h0, 24'h303836}, g);
    chk("sleep silent", 32'h0, 32'(g));
    chk("asleep", 32'h0, 32'(port_awake));
    cmd({8'h0, 24'h303031}, g);
    chk("asleep silent", 32'h0, 32'(g));
    cmd({8'h31, 24'h303835}, g);
    chk("other wake", 32'h0, 32'(g));
    cmd({8'h30, 24'h303835}, g);
    chk("wake echo", 32'h1, 32'(g));
    rdc("wake id", 4'h8, 32'hffffff, 32'h303835);
    cmd({8'h35, 24'h303538}, g);
    chk("woken echo", 32'h1, 32'(g));
    chk("cmd data", 32'h35, 32'(cmd_data));
    $display("test serial done");
  endtask : t_serial
  task automatic t_disc;
    logic [1:0] r;
    for (int i = 0; i < 5; i++)
    begin
      axw(4'hc, 32'(1 << i), r);
      repeat (5) @(posedge aclk);
      chk("orders", 32'(1 << i), 32'(orders));
    end
    arc_transferred <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      motion_sel <= 2'(i);
      repeat (6) @(posedge aclk);
      rdc("motion", 4'hc, 32'hf00, 32'(1 << (i + 8)));
    end
    arc_transferred <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      stat_in <= 3'(1 << i);
      repeat (6) @(posedge aclk);
      rdc("status pins", 4'hc, 32'h7f00, 32'(1 << (i + 12)));
    end
    stat_in <= 3'h0;
    $display("test disc done");
  endtask : t_disc
  task automatic t_ids;
    logic g;
    do_reset(3'h2);
    chk("awake id2", 32'h0, 32'(port_awake));
    cmd({8'h31, 24'h303835}, g);
    chk("wake wrong id", 32'h0, 32'(g));
    cmd({8'h32, 24'h303835}, g);
    chk("wake id2", 32'h1, 32'(g));
    do_reset(3'h6);
    cmd({8'h32, 24'h303835}, g);
    chk("wake reserved", 32'h0, 32'(g));
    $display("test ids done");
  endtask : t_ids
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Main sequence.
  initial
  begin
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid, motion_sel, stat_in, arc_transferred} <= '0;
    {wstrb, bready, rready, aresetn, sw_on} <= {6'h3f, 4'h0};
    do_reset(3'h0);
    t_serial();
    t_disc();
    t_ids();
    report_and_stop();
  end
  // Watchdog, well beyond the expected thirteen thousand cycles.
  initial
  begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    report_and_stop();
  end
endmodule : testbench
